/* File: bench/lsw_nvm_model.sv */
// non-volatile memory responder for one loop's save request
`timescale 1ns/1ns

module lsw_nvm_model #(
  parameter int DELAY = 2
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       nvm_write,
  output logic            nvm_done,
  output logic [7:0]      writes
);
  int   cnt;
  logic served;

  // one done pulse per request; a request held high after it is not written twice
  always @(posedge sys_clk) begin
    if (reset) begin
      nvm_done <= 1'b0;
      cnt      <= 0;
      served   <= 1'b0;
      writes   <= 8'h00;
    end else begin
      nvm_done <= 1'b0;
      if (!nvm_write) begin
        cnt    <= 0;
        served <= 1'b0;
      end else if (!served) begin
        if (cnt == DELAY) begin
          nvm_done <= 1'b1;
          served   <= 1'b1;
          writes   <= writes + 8'h01;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule

/* File: bench/test_loop_status_word.sv */
// self-checking bench for the loop status word block
`timescale 1ns/1ns

module test_loop_status_word;
  logic                        sys_clk;
  logic                        reset;
  logic                        ce;
  lsw_pkg::lsw_bus_req_t       bus;
  logic [15:0]                 rdata;
  lsw_pkg::lsw_meas_t [1:0]    meas;
  logic [1:0]                  nvm_done;
  logic [1:0]                  nvm_write;
  lsw_pkg::lsw_pid_t [1:0]     active_pid;
  logic                        irq;
  logic [7:0]                  writes0;
  logic [7:0]                  writes1;
  int                          fail_count;
  int                          tests_run;
  logic [15:0]                 t_tab [6] = '{16'hFFCE, 16'h0032, 16'h0033, 16'h0064, 16'h00C8, 16'h00C9};
  logic [15:0]                 a_tab [6] = '{16'h0001, 16'h0001, 16'h0000, 16'h0002, 16'h0002, 16'h0000};
  logic [15:0]                 c_tab [4] = '{16'h0063, 16'h0064, 16'h0226, 16'h0227};
  logic [15:0]                 h_tab [4] = '{16'h0004, 16'h0000, 16'h0000, 16'h2000};
  logic [15:0]                 l_tab [7] = '{16'h0008, 16'h0010, 16'h1000, 16'h4000, 16'h4000, 16'h4000, 16'h4000};

  lsw_top dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .bus(bus), .rdata(rdata), .meas(meas),
               .nvm_done(nvm_done), .nvm_write(nvm_write), .active_pid(active_pid), .irq(irq));
  // loop 2 memory is slow so a request can be withdrawn mid-write
  lsw_nvm_model #(.DELAY(2)) nvm0 (.sys_clk(sys_clk), .reset(reset), .nvm_write(nvm_write[0]),
                                   .nvm_done(nvm_done[0]), .writes(writes0));
  lsw_nvm_model #(.DELAY(20)) nvm1 (.sys_clk(sys_clk), .reset(reset), .nvm_write(nvm_write[1]),
                                    .nvm_done(nvm_done[1]), .writes(writes1));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    rd_reg(a, v);
    chk({32'h0, v & m}, {32'h0, e});
  endtask

  task automatic wait_save(input logic [7:0] a);
    logic [15:0] v;
    int          n;
    n = 0;
    v = 16'h0000;
    while (v[15] !== 1'b1 && n < 40) begin
      rd_reg(a, v);
      n++;
    end
    chk({47'h0, v[15]}, 48'h1);
    if (v[15] !== 1'b1) close_out();
  endtask

  task automatic set_lvl(input int k, input logic on);
    @(posedge sys_clk);
    case (k)
      0: meas[0].autotune_running <= on;
      1: meas[0].output_on <= on;
      2: meas[0].cj_fault <= on;
      3: meas[0].sensor_absent <= on;
      4: meas[0].sensor_open <= on;
      5: meas[0].temperature <= on ? 16'hFE6F : 16'h0000;
      default: meas[0].temperature <= on ? 16'h0FA1 : 16'h0000;
    endcase
  endtask

  initial begin
    fail_count = 0;
    tests_run  = 0;
    reset      = 1'b1;
    ce         = 1'b1;
    bus        = '0;
    meas       = '0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    settle();
    rdchk(8'h00, 16'hFFFF, 16'h0903);
    rdchk(8'h00, 16'hFFFF, 16'h0103);
    rdchk(8'h01, 16'hFFFF, 16'h0903);
    wr(8'h00, 16'hFFFF);
    wr(8'h01, 16'h0000);
    wr(8'h02, 16'hFFFF);
    settle();
    rdchk(8'h00, 16'hFFFF, 16'h0103);
    wr(8'h04, 16'h0004);
    settle();
    rdchk(8'h00, 16'hFFFF, 16'h0003);
    wr(8'h10, 16'h0064);
    wr(8'h11, 16'h00C8);
    wr(8'h12, 16'hFFCE);
    wr(8'h13, 16'h0032);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      meas[0].temperature <= t_tab[i];
      settle();
      rdchk(8'h00, 16'h0003, a_tab[i]);
    end
    @(posedge sys_clk);
    meas[0].temperature <= 16'h0000;
    meas[1].temperature <= 16'h0001;
    settle();
    rdchk(8'h01, 16'h0003, 16'h0000);
    wr(8'h14, 16'h0064);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      meas[0].heater_current <= c_tab[i];
      settle();
      rdchk(8'h00, 16'h2004, h_tab[i]);
    end
    wr(8'h14, 16'h0227);
    settle();
    rdchk(8'h00, 16'h0200, 16'h0200);
    wr(8'h14, 16'h0064);
    settle();
    rdchk(8'h00, 16'h0200, 16'h0000);
    wr(8'h10, 16'h00C9);
    settle();
    rdchk(8'h00, 16'h0200, 16'h0200);
    wr(8'h10, 16'h0064);
    @(posedge sys_clk);
    meas[0].heater_current <= 16'h0080;
    for (int k = 0; k < 7; k++) begin
      set_lvl(k, 1'b1);
      settle();
      rdchk(8'h00, 16'h5018, l_tab[k]);
      set_lvl(k, 1'b0);
      settle();
      rdchk(8'h00, 16'h5018, 16'h0000);
    end
    @(posedge sys_clk);
    meas[0].temperature <= 16'h0FA0;
    settle();
    rdchk(8'h00, 16'h4000, 16'h0000);
    // event status and mask
    wr(8'h03, 16'hFFFF);
    rdchk(8'h03, 16'hFFFF, 16'h7F7F);
    wr(8'h03, 16'h0008);
    rdchk(8'h02, 16'h0000, 16'h0000);
    @(posedge sys_clk);
    meas[0].heater_current <= 16'h0063;
    settle();
    chk({47'h0, irq}, 48'h0);
    @(posedge sys_clk);
    meas[0].cj_fault <= 1'b1;
    settle();
    chk({47'h0, irq}, 48'h1);
    rdchk(8'h02, 16'hFFFF, 16'h0009);
    settle();
    chk({47'h0, irq}, 48'h0);
    // sensor fault event with its mask bit open
    wr(8'h03, 16'h0020);
    set_lvl(3, 1'b1);
    settle();
    chk({47'h0, irq}, 48'h1);
    rdchk(8'h02, 16'h0020, 16'h0020);
    set_lvl(3, 1'b0);
    settle();
    chk({47'h0, irq}, 48'h0);
    // tuned constants take precedence over host ones until released
    @(posedge sys_clk);
    meas[0].tuned           <= {16'h0011, 16'h0022, 16'h0033};
    meas[0].autotune_update <= 1'b1;
    @(posedge sys_clk);
    meas[0].autotune_update <= 1'b0;
    settle();
    chk(active_pid[0], {16'h0011, 16'h0022, 16'h0033});
    rdchk(8'h00, 16'h0400, 16'h0400);
    wr(8'h15, 16'h0055);
    settle();
    chk(active_pid[0], {16'h0011, 16'h0022, 16'h0033});
    wr(8'h04, 16'h0014);
    settle();
    rdchk(8'h00, 16'h0400, 16'h0000);
    chk(active_pid[0], {16'h0055, 16'h0000, 16'h0000});
    wr(8'h04, 16'h0005);
    wait_save(8'h00);
    chk({40'h0, writes0}, 48'h1);
    wr(8'h04, 16'h0004);
    settle();
    rdchk(8'h00, 16'h8000, 16'h0000);
    // withdrawn loop 2 request: memory write completes, flag stays low
    wr(8'h04, 16'h0006);
    wr(8'h04, 16'h0004);
    repeat (40) @(posedge sys_clk);
    rdchk(8'h01, 16'h8000, 16'h0000);
    chk({40'h0, writes1}, 48'h1);
    wr(8'h04, 16'h0006);
    wait_save(8'h01);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    settle();
    rdchk(8'h01, 16'h8800, 16'h0800);
    close_out();
  end
endmodule

/* File: hdl/lsw_loop_flags.sv */
// condition flags, standby and pid constant selection for one loop
`timescale 1ns/1ns
`include "lsw_map.svh"

module lsw_loop_flags (
  input  logic               sys_clk,
  input  logic               reset,
  input  logic               ce,
  input  lsw_pkg::lsw_meas_t meas,
  input  lsw_pkg::lsw_cfg_t  cfg,
  input  logic               run,
  input  logic               refresh,
  input  logic               pid_release,
  input  logic               save_done,
  output logic [15:0]        word,
  output lsw_pkg::lsw_pid_t  active_pid
);
  logic              standby;
  logic              next_standby;
  logic              pid_computed;
  logic              next_pid_computed;
  logic              sensor_fault;
  logic              setting_fault;
  logic [15:0]       next_word;
  lsw_pkg::lsw_pid_t next_active_pid;

  always_comb begin
    sensor_fault = meas.sensor_absent || meas.sensor_open || (meas.temperature < `LSW_TEMP_MIN) ||
                   (meas.temperature > `LSW_TEMP_MAX);
    setting_fault = (cfg.al1_lo > cfg.al1_hi) || (cfg.al2_lo > cfg.al2_hi) ||
                    (cfg.hb_thr > `LSW_CT_LIMIT);
    next_standby = standby && !refresh;
    next_pid_computed = meas.autotune_update || (pid_computed && !pid_release);
    next_active_pid = pid_computed ? active_pid : cfg.pid;
    if (meas.autotune_update) next_active_pid = meas.tuned;
    next_word = 16'h0000;
    next_word[`LSW_BIT_ALARM_TWO] = (meas.temperature >= cfg.al2_lo) && (meas.temperature <= cfg.al2_hi);
    next_word[`LSW_BIT_ALARM_ONE] = (meas.temperature >= cfg.al1_lo) && (meas.temperature <= cfg.al1_hi);
    next_word[`LSW_BIT_BURNOUT] = meas.heater_current < cfg.hb_thr;
    next_word[`LSW_BIT_AUTOTUNE] = meas.autotune_running;
    next_word[`LSW_BIT_OUTPUT] = meas.output_on;
    next_word[`LSW_BIT_HALTED] = !run;
    next_word[`LSW_BIT_SETTING] = setting_fault;
    next_word[`LSW_BIT_PID] = pid_computed;
    next_word[`LSW_BIT_STANDBY] = standby;
    next_word[`LSW_BIT_COLD_JCT] = meas.cj_fault;
    next_word[`LSW_BIT_OVERFLOW] = meas.heater_current > `LSW_CT_LIMIT;
    next_word[`LSW_BIT_SENSOR] = sensor_fault;
    next_word[`LSW_BIT_SAVE] = save_done;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      standby      <= 1'b1;
      pid_computed <= 1'b0;
      active_pid   <= '0;
      word         <= `LSW_RST_WORD;
    end else if (ce) begin
      standby      <= next_standby;
      pid_computed <= next_pid_computed;
      active_pid   <= next_active_pid;
      word         <= next_word;
    end
  end
endmodule

/* File: hdl/lsw_map.svh */
// register offsets, flag positions, reset values and limits of the loop status word block
// Overview of operation
// - each loop has its own status word, same bit layout, every used bit a flag
// - bits 5 to 7 unused; bit 8 is stop, bit 9 is setting error
// - alarm flags (bits 0, 1) are 1 while temperature is inside their range
// - burnout flag (bit 2) is 1 while heater current is below the threshold
// - autotune flag (bit 3) is 1 while autotuning runs, 0 once it ends
// - output flag (bit 4) is 1 while the control output is on
// - pid flag (bit 10) sets when autotuning updates the pid constants
// - while the pid flag is 1 host pid constants are ignored, else loaded
// - standby flag (bit 11) is 1 after reset until the first refresh exchange
// - cold junction flag (bit 12) is 1 on a cold junction sensor fault
// - overflow flag (bit 13) is 1 while heater current exceeds 55.0 A
// - sensor flag (bit 14) on absent or open sensor or out-of-range input
// - rising save request writes non-volatile memory, then save flag (bit 15) sets
// - falling save request clears the save flag; it is 0 after reset
// - stop flag is 0 while the loop controls and 1 while it is stopped
// - setting error flag is 1 while a host set value is invalid
`ifndef LSW_MAP_SVH
`define LSW_MAP_SVH

`define LSW_OFS_LOOP1_FLAGS 8'h00
`define LSW_OFS_LOOP2_FLAGS 8'h01
`define LSW_OFS_EVT_STATUS  8'h02
`define LSW_OFS_EVT_MASK    8'h03
`define LSW_OFS_CONTROL     8'h04
`define LSW_OFS_CFG_LOOP1   8'h10
`define LSW_OFS_CFG_LOOP2   8'h20

`define LSW_CFG_AL1_LO 3'h0
`define LSW_CFG_AL1_HI 3'h1
`define LSW_CFG_AL2_LO 3'h2
`define LSW_CFG_AL2_HI 3'h3
`define LSW_CFG_HB_THR 3'h4
`define LSW_CFG_PID_P  3'h5
`define LSW_CFG_PID_I  3'h6
`define LSW_CFG_PID_D  3'h7

`define LSW_BIT_ALARM_TWO 0
`define LSW_BIT_ALARM_ONE 1
`define LSW_BIT_BURNOUT   2
`define LSW_BIT_AUTOTUNE  3
`define LSW_BIT_OUTPUT    4
`define LSW_BIT_HALTED    8
`define LSW_BIT_SETTING   9
`define LSW_BIT_PID       10
`define LSW_BIT_STANDBY   11
`define LSW_BIT_COLD_JCT  12
`define LSW_BIT_OVERFLOW  13
`define LSW_BIT_SENSOR    14
`define LSW_BIT_SAVE      15

`define LSW_CTRL_SAVE1   0
`define LSW_CTRL_RUN1    2
`define LSW_CTRL_PIDREL1 4

`define LSW_CTRL_STORE_MASK 16'h000F
`define LSW_EVT_USED_MASK   16'h7F7F
`define LSW_RST_CTRL        16'h0000
`define LSW_RST_MASK        16'h0000
`define LSW_RST_STATUS      16'h0000
`define LSW_RST_WORD        16'h0800
`define LSW_RST_CFG_FIELD   16'h0000

// heater current in 0.1 A steps, temperature in signed 0.1 degree steps
`define LSW_CT_LIMIT 16'h0226
`define LSW_TEMP_MIN 16'shFE70
`define LSW_TEMP_MAX 16'sh0FA0

`endif

/* File: hdl/lsw_pkg.sv */
// types shared by the loop status word block
package lsw_pkg;

  typedef struct packed {
    logic [15:0] p;
    logic [15:0] i;
    logic [15:0] d;
  } lsw_pid_t;

  typedef struct packed {
    logic signed [15:0] temperature;
    logic [15:0]        heater_current;
    logic               autotune_running;
    logic               autotune_update;
    lsw_pid_t           tuned;
    logic               output_on;
    logic               cj_fault;
    logic               sensor_absent;
    logic               sensor_open;
  } lsw_meas_t;

  typedef struct packed {
    logic signed [15:0] al1_lo;
    logic signed [15:0] al1_hi;
    logic signed [15:0] al2_lo;
    logic signed [15:0] al2_hi;
    logic [15:0]        hb_thr;
    lsw_pid_t           pid;
  } lsw_cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } lsw_bus_req_t;

  typedef enum logic [2:0] {
    LSW_SAVE_IDLE  = 3'b001,
    LSW_SAVE_WRITE = 3'b010,
    LSW_SAVE_DONE  = 3'b100
  } lsw_save_state_t;

endpackage

/* File: hdl/lsw_save_ctl.sv */
// save request sequencer for one loop
`timescale 1ns/1ns

module lsw_save_ctl (
  input  logic sys_clk,
  input  logic reset,
  input  logic ce,
  input  logic save_req,
  input  logic nvm_done,
  output logic nvm_write,
  output logic save_done
);
  lsw_pkg::lsw_save_state_t state, next_state;
  logic                     req_q;

  always_comb begin
    next_state = state;
    unique case (state)
      lsw_pkg::LSW_SAVE_IDLE: begin
        if (save_req && !req_q) next_state = lsw_pkg::LSW_SAVE_WRITE;
      end
      lsw_pkg::LSW_SAVE_WRITE: begin
        // a request dropped mid-write lets the write finish but reports nothing
        if (nvm_done) next_state = save_req ? lsw_pkg::LSW_SAVE_DONE : lsw_pkg::LSW_SAVE_IDLE;
      end
      lsw_pkg::LSW_SAVE_DONE: begin
        if (!save_req && req_q) next_state = lsw_pkg::LSW_SAVE_IDLE;
      end
      default: next_state = lsw_pkg::LSW_SAVE_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= lsw_pkg::LSW_SAVE_IDLE;
      req_q <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      req_q <= save_req;
    end
  end

  assign nvm_write = (state == lsw_pkg::LSW_SAVE_WRITE);
  assign save_done = (state == lsw_pkg::LSW_SAVE_DONE);
endmodule

/* File: hdl/lsw_top.sv */
// register port, event interrupt and two loop status word channels
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "lsw_map.svh"

module lsw_top (
  input  logic                           sys_clk,
  input  logic                           reset,
  input  logic                           ce,
  input  lsw_pkg::lsw_bus_req_t          bus,
  output logic [15:0]                    rdata,
  input  lsw_pkg::lsw_meas_t [1:0]       meas,
  input  logic [1:0]                     nvm_done,
  output logic [1:0]                     nvm_write,
  output lsw_pkg::lsw_pid_t [1:0]        active_pid,
  output logic                           irq
);

  logic [1:0][15:0]             loop_word;
  logic [1:0][15:0]             word_prev;
  logic [1:0][15:0]             rose;
  lsw_pkg::lsw_cfg_t [1:0]      cfg_q;
  lsw_pkg::lsw_cfg_t [1:0]      next_cfg;
  logic [15:0]                  ctrl_q;
  logic [15:0]                  next_ctrl;
  logic [15:0]                  mask_q;
  logic [15:0]                  next_mask;
  logic [15:0]                  status_q;
  logic [15:0]                  next_status;
  logic [15:0]                  next_rdata;
  logic [15:0]                  events;
  logic [1:0]                   refresh;
  logic [1:0]                   pid_release;
  logic [1:0]                   save_done;
  logic                         hit_cfg;
  logic                         cfg_loop;
  logic [2:0]                   cfg_idx;

  // config windows sit at 0x10 and 0x20, eight words each
  assign cfg_loop = bus.addr[5];
  assign cfg_idx  = bus.addr[2:0];
  assign hit_cfg  = (bus.addr[7:6] == 2'h0) && (bus.addr[5] != bus.addr[4]) && !bus.addr[3];

  function automatic logic [15:0] cfg_read(
    input lsw_pkg::lsw_cfg_t c,
    input logic [2:0]        idx
  );
    logic [15:0] v;
    v = 16'h0000;
    unique case (idx)
      `LSW_CFG_AL1_LO: v = c.al1_lo;
      `LSW_CFG_AL1_HI: v = c.al1_hi;
      `LSW_CFG_AL2_LO: v = c.al2_lo;
      `LSW_CFG_AL2_HI: v = c.al2_hi;
      `LSW_CFG_HB_THR: v = c.hb_thr;
      `LSW_CFG_PID_P:  v = c.pid.p;
      `LSW_CFG_PID_I:  v = c.pid.i;
      `LSW_CFG_PID_D:  v = c.pid.d;
    endcase
    return v;
  endfunction

  function automatic lsw_pkg::lsw_cfg_t cfg_write(
    input lsw_pkg::lsw_cfg_t c,
    input logic [2:0]        idx,
    input logic [15:0]       data
  );
    lsw_pkg::lsw_cfg_t r;
    r = c;
    unique case (idx)
      `LSW_CFG_AL1_LO: r.al1_lo = data;
      `LSW_CFG_AL1_HI: r.al1_hi = data;
      `LSW_CFG_AL2_LO: r.al2_lo = data;
      `LSW_CFG_AL2_HI: r.al2_hi = data;
      `LSW_CFG_HB_THR: r.hb_thr = data;
      `LSW_CFG_PID_P:  r.pid.p = data;
      `LSW_CFG_PID_I:  r.pid.i = data;
      `LSW_CFG_PID_D:  r.pid.d = data;
    endcase
    return r;
  endfunction

  // fault and completion flags that are worth an interrupt, packed into one byte
  function automatic logic [7:0] evt_bits(input logic [15:0] w);
    return {1'b0, w[`LSW_BIT_SAVE], w[`LSW_BIT_SENSOR], w[`LSW_BIT_OVERFLOW],
            w[`LSW_BIT_COLD_JCT], w[`LSW_BIT_PID], w[`LSW_BIT_SETTING], w[`LSW_BIT_BURNOUT]};
  endfunction

  assign rose   = loop_word & ~word_prev;
  assign events = {evt_bits(rose[1]), evt_bits(rose[0])};

  always_comb begin
    next_cfg    = cfg_q;
    next_ctrl   = ctrl_q;
    next_mask   = mask_q;
    next_status = status_q;
    next_rdata  = 16'h0000;
    refresh     = 2'b00;
    pid_release = 2'b00;
    if (bus.wr) begin
      if (hit_cfg) begin
        next_cfg[cfg_loop] = cfg_write(cfg_q[cfg_loop], cfg_idx, bus.wdata);
      end else if (bus.addr == `LSW_OFS_CONTROL) begin
        next_ctrl   = bus.wdata & `LSW_CTRL_STORE_MASK;
        pid_release = bus.wdata[`LSW_CTRL_PIDREL1 +: 2];
      end else if (bus.addr == `LSW_OFS_EVT_MASK) begin
        next_mask = bus.wdata & `LSW_EVT_USED_MASK;
      end
      // the two status words and the event register take no writes
    end
    if (bus.rd) begin
      if (hit_cfg) begin
        next_rdata = cfg_read(cfg_q[cfg_loop], cfg_idx);
      end else begin
        case (bus.addr)
          `LSW_OFS_LOOP1_FLAGS: begin
            next_rdata = loop_word[0];
            refresh[0] = 1'b1;
          end
          `LSW_OFS_LOOP2_FLAGS: begin
            next_rdata = loop_word[1];
            refresh[1] = 1'b1;
          end
          `LSW_OFS_EVT_STATUS: begin
            next_rdata  = status_q;
            next_status = 16'h0000;
          end
          `LSW_OFS_EVT_MASK: next_rdata = mask_q;
          `LSW_OFS_CONTROL:  next_rdata = ctrl_q;
          default:           next_rdata = 16'h0000;
        endcase
      end
    end
    // an event in the clearing read's own cycle survives the clear
    next_status = next_status | events;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_q     <= {16{`LSW_RST_CFG_FIELD}};
      ctrl_q    <= `LSW_RST_CTRL;
      mask_q    <= `LSW_RST_MASK;
      status_q  <= `LSW_RST_STATUS;
      rdata     <= 16'h0000;
      word_prev <= {2{`LSW_RST_WORD}};
    end else if (ce) begin
      cfg_q     <= next_cfg;
      ctrl_q    <= next_ctrl;
      mask_q    <= next_mask;
      status_q  <= next_status;
      rdata     <= next_rdata;
      word_prev <= loop_word;
    end
  end

  assign irq = |(status_q & mask_q);

  for (genvar l = 0; l < 2; l++) begin : g_loop
    lsw_save_ctl u_save (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .ce        (ce),
      .save_req  (ctrl_q[`LSW_CTRL_SAVE1 + l]),
      .nvm_done  (nvm_done[l]),
      .nvm_write (nvm_write[l]),
      .save_done (save_done[l])
    );

    lsw_loop_flags u_flags (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .ce          (ce),
      .meas        (meas[l]),
      .cfg         (cfg_q[l]),
      .run         (ctrl_q[`LSW_CTRL_RUN1 + l]),
      .refresh     (refresh[l]),
      .pid_release (pid_release[l]),
      .save_done   (save_done[l]),
      .word        (loop_word[l]),
      .active_pid  (active_pid[l])
    );
  end

  // checks on loop 1; loop 2 is another instance of the same modules
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset || !ce);

  sequence save_written_s;
    nvm_write[0] && nvm_done[0] && ctrl_q[`LSW_CTRL_SAVE1] ##1 ctrl_q[`LSW_CTRL_SAVE1];
  endsequence

  sequence save_dropped_s;
    $fell(ctrl_q[`LSW_CTRL_SAVE1]);
  endsequence

  property save_sets_p;
    save_written_s |=> loop_word[0][`LSW_BIT_SAVE];
  endproperty

  property save_clears_p;
    save_dropped_s |-> ##2 !loop_word[0][`LSW_BIT_SAVE];
  endproperty

  save_start_a: assert property ($rose(ctrl_q[`LSW_CTRL_SAVE1]) && !nvm_write[0] |=> nvm_write[0])
    else $error("save request did not start a memory write");

  save_done_a: assert property (save_sets_p)
    else $error("save flag missing after memory write");

  save_clear_a: assert property (save_clears_p)
    else $error("save flag not cleared after request dropped");

  save_after_reset_a: assert property ($past(reset) |-> !loop_word[0][`LSW_BIT_SAVE])
    else $error("save flag set right after reset");

  stop_flag_a: assert property ($changed(ctrl_q[`LSW_CTRL_RUN1]) |=>
      loop_word[0][`LSW_BIT_HALTED] == !$past(ctrl_q[`LSW_CTRL_RUN1]))
    else $error("stop flag disagrees with run control");

  status_readonly_a: assert property (bus.wr && (bus.addr == `LSW_OFS_LOOP1_FLAGS) && !bus.rd |=>
      $stable(ctrl_q) && $stable(mask_q) && $stable(cfg_q))
    else $error("write to status word changed state");

  standby_end_a: assert property (refresh[0] |-> ##2 !loop_word[0][`LSW_BIT_STANDBY])
    else $error("standby flag still set after refresh");

  standby_reset_a: assert property ($past(reset) |-> loop_word[0][`LSW_BIT_STANDBY])
    else $error("standby flag not set after reset");

  overflow_flag_a: assert property ((meas[0].heater_current > `LSW_CT_LIMIT)
      |=> loop_word[0][`LSW_BIT_OVERFLOW])
    else $error("heater current overflow not flagged");

  burnout_flag_a: assert property ((meas[0].heater_current < cfg_q[0].hb_thr)
      |=> loop_word[0][`LSW_BIT_BURNOUT])
    else $error("heater burnout not flagged");

  alarm_range_a: assert property ((meas[0].temperature >= cfg_q[0].al1_lo) &&
      (meas[0].temperature <= cfg_q[0].al1_hi) && $stable(cfg_q[0]) |=> loop_word[0][`LSW_BIT_ALARM_ONE])
    else $error("alarm one flag missing inside range");

  pid_set_a: assert property (meas[0].autotune_update |-> ##2 loop_word[0][`LSW_BIT_PID])
    else $error("pid flag not set after autotune update");

  pid_ignore_a: assert property (loop_word[0][`LSW_BIT_PID] && !pid_release[0] &&
      !$past(pid_release[0]) && !meas[0].autotune_update |=> $stable(active_pid[0]))
    else $error("host pid constants loaded while pid flag set");

  setting_flag_a: assert property ((cfg_q[0].al1_lo > cfg_q[0].al1_hi)
      |=> loop_word[0][`LSW_BIT_SETTING])
    else $error("invalid alarm range not flagged");

  sensor_irq_a: assert property ($rose(loop_word[0][`LSW_BIT_SENSOR]) && mask_q[5] |=> irq)
    else $error("sensor fault event raised no interrupt");

endmodule
